// file: logic/sbi_core.sv
`timescale 1ns/1ps
module sbi_core
  import sbi_pkg::*;
#(
  parameter int BL = BURST_LEN,
  parameter int CL = CAS_LAT
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [1:0]        ba,
  input  wire logic              ap_en,
  input  wire logic [COL_W-1:0]  col,
  input  wire logic              dqm,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe,
  output logic                   wr_acc_vld,
  output logic      [1:0]        wr_acc_bank,
  output logic      [DATA_W-1:0] wr_acc_data,
  output logic [NUM_BANKS-1:0]   pre_start
);

  logic              cmd_rd;
  logic              cmd_wr;
  logic              cmd_new;
  logic              run_ff;
  logic              nxt_run;
  logic              is_wr_ff;
  logic              nxt_is_wr;
  logic [1:0]        bank_ff;
  logic [1:0]        nxt_bank;
  logic [COL_W-1:0]  col_ff;
  logic [COL_W-1:0]  nxt_col;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  nxt_cnt;
  logic              beat_now;
  logic              beat_wr;
  logic [1:0]        beat_bank;
  logic [COL_W-1:0]  beat_col;
  logic              end_now;
  logic              wr_vld_ff;
  logic              nxt_wr_vld;
  logic [1:0]        wr_bank_ff;
  logic [1:0]        nxt_wr_bank;
  logic [DATA_W-1:0] wr_data_ff;
  logic [DATA_W-1:0] nxt_wr_data;
  logic [DATA_W-1:0] rd_word;

  function automatic logic [DATA_W-1:0] read_word(input logic [1:0] b,
                                                   input logic [COL_W-1:0] c);
    read_word = {b, (DATA_W - 2 - COL_W)'(0), c};
  endfunction

  // ----------------------------------------------------------------
  // Command decode; a column command to any bank cuts the running burst.
  // ----------------------------------------------------------------
  assign cmd_rd  = ~cs_n & ras_n & ~cas_n & we_n;
  assign cmd_wr  = ~cs_n & ras_n & ~cas_n & ~we_n;
  assign cmd_new = cmd_rd | cmd_wr;

  // ----------------------------------------------------------------
  // Burst sequencer.
  // ----------------------------------------------------------------
  always_comb begin
    nxt_run   = run_ff;
    nxt_is_wr = is_wr_ff;
    nxt_bank  = bank_ff;
    nxt_col   = col_ff;
    nxt_cnt   = cnt_ff;
    if (cmd_new) begin
      nxt_run   = 1'b1;
      nxt_is_wr = cmd_wr;
      nxt_bank  = ba;
      nxt_col   = col + 1'b1;
      nxt_cnt   = CNT_W'(BL - 1);
    end else if (run_ff) begin
      nxt_col = col_ff + 1'b1;
      nxt_cnt = cnt_ff - 1'b1;
      nxt_run = (cnt_ff != CNT_W'(1));
    end
  end

  assign beat_now  = cmd_new | run_ff;
  assign beat_wr   = cmd_new ? cmd_wr : is_wr_ff;
  assign beat_bank = cmd_new ? ba : bank_ff;
  assign beat_col  = cmd_new ? col : col_ff;
  assign end_now   = run_ff & ~cmd_new & (cnt_ff == CNT_W'(1));
  assign rd_word   = read_word(beat_bank, beat_col);

  // ----------------------------------------------------------------
  // Write data capture: the word on a new command's edge belongs to it.
  // ----------------------------------------------------------------
  always_comb begin
    nxt_wr_vld  = beat_now & beat_wr & ~dqm;
    nxt_wr_bank = beat_bank;
    nxt_wr_data = dq_in;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      run_ff     <= 1'b0;
      is_wr_ff   <= 1'b0;
      bank_ff    <= 2'h0;
      col_ff     <= '0;
      cnt_ff     <= CNT_RST;
      wr_vld_ff  <= 1'b0;
      wr_bank_ff <= 2'h0;
      wr_data_ff <= '0;
    end else begin
      run_ff     <= nxt_run;
      is_wr_ff   <= nxt_is_wr;
      bank_ff    <= nxt_bank;
      col_ff     <= nxt_col;
      cnt_ff     <= nxt_cnt;
      wr_vld_ff  <= nxt_wr_vld;
      wr_bank_ff <= nxt_wr_bank;
      wr_data_ff <= nxt_wr_data;
    end
  end

  assign wr_acc_vld  = wr_vld_ff;
  assign wr_acc_bank = wr_bank_ff;
  assign wr_acc_data = wr_data_ff;

  // ----------------------------------------------------------------
  // Read data path; a write cuts pending read output at once.
  // ----------------------------------------------------------------
  sbi_rd_pipe #(
    .CL (CL),
    .W  (DATA_W)
  ) u_rd_pipe (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .beat_vld  (beat_now & ~beat_wr),
    .beat_data (rd_word),
    .flush     (cmd_wr),
    .dqm       (dqm),
    .dq_out    (dq_out),
    .dq_oe     (dq_oe)
  );

  // ----------------------------------------------------------------
  // Per-bank state.
  // ----------------------------------------------------------------
  sbi_bank_if bif [NUM_BANKS] ();

  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    assign bif[g].rd_go     = cmd_rd & (ba == 2'(g));
    assign bif[g].wr_go     = cmd_wr & (ba == 2'(g));
    assign bif[g].ap        = ap_en;
    assign bif[g].other_go  = cmd_new & (ba != 2'(g));
    assign bif[g].burst_end = end_now & (bank_ff == 2'(g));
    assign pre_start[g]     = bif[g].pre_start;

    sbi_bank u_bank (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .bif     (bif[g])
    );
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  property p_read_stops_write;
    @(posedge mclk) disable iff (sys_rst)
      cmd_rd |=> !wr_acc_vld;
  endproperty
  a_read_stops_write: assert property (p_read_stops_write)
    else $error("write word accepted on interrupting read edge");

  property p_write_takes_over;
    @(posedge mclk) disable iff (sys_rst)
      (cmd_wr && !dqm) |=> (wr_acc_vld && wr_acc_bank == $past(ba)
                            && wr_acc_data == $past(dq_in));
  endproperty
  a_write_takes_over: assert property (p_write_takes_over)
    else $error("new write did not own the word on its edge");

endmodule // sbi_core

// file: logic/sbi_pkg.sv
// Functional notes
// - Cross-bank interrupt acts alike whether the interrupting command has auto precharge or not.
// - An auto-precharge burst cut by another bank still starts its own precharge.
// - Read cut by read elsewhere: new data takes the bus CAS latency later.
// - Read cut by write elsewhere ends its output on the write's edge.
// - Write cut by read: ends at the read; last word is one clock before.
// - Write cut by write: ends at the new write; last word one clock before.
// - Auto-precharge read cut by read: precharge starts at the new read's edge.
// - Auto-precharge read cut by write: ends and precharges at the write's edge.
// - Auto-precharge write cut by read: ends at the read, data CAS later.
// - That write's precharge starts after write recovery counted from the read.
// - Auto-precharge write cut by write: precharge after recovery from that write.
// - Mask during a read turns the outputs off two clocks later.
package sbi_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int NUM_BANKS     = 4;
  localparam int DATA_W        = 16;
  localparam int COL_W         = 9;
  localparam int CAS_LAT       = 2;
  localparam int BURST_LEN     = 4;
  localparam int DQZ_CYC       = 2;
  localparam int TWR_NS        = 15;
  localparam int TRP_NS        = 19;
  // Least times round up to whole cycles, never below one.
  localparam int TWR_CYC_RAW   = (TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRP_CYC_RAW   = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TWR_CYC       = (TWR_CYC_RAW < 1) ? 1 : TWR_CYC_RAW;
  localparam int TRP_CYC       = (TRP_CYC_RAW < 1) ? 1 : TRP_CYC_RAW;
  localparam int CNT_W         = 4;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_OPEN,
    ST_RD,
    ST_WR,
    ST_RDAP,
    ST_WRAP,
    ST_WREC,
    ST_PRE
  } sbi_state_e;

endpackage

// file: logic/sbi_bank_if.sv
`timescale 1ns/1ps
interface sbi_bank_if;
  import sbi_pkg::*;
  logic       rd_go;
  logic       wr_go;
  logic       ap;
  logic       other_go;
  logic       burst_end;
  logic       pre_start;
  sbi_state_e state;

  modport core (output rd_go, output wr_go, output ap, output other_go,
                output burst_end, input pre_start, input state);
  modport bank (input rd_go, input wr_go, input ap, input other_go,
                input burst_end, output pre_start, output state);
endinterface

// file: logic/sbi_bank.sv
`timescale 1ns/1ps
module sbi_bank
  import sbi_pkg::*;
#(
  parameter int TWR = TWR_CYC,
  parameter int TRP = TRP_CYC
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  sbi_bank_if.bank  bif
);

  sbi_state_e       state_ff;
  sbi_state_e       nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             pre_ff;
  logic             nxt_pre;

  // ----------------------------------------------------------------
  // Bank sequencing.
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_pre   = 1'b0;
    case (state_ff)
      ST_OPEN: begin
        if (bif.rd_go) begin
          nxt_state = bif.ap ? ST_RDAP : ST_RD;
        end else if (bif.wr_go) begin
          nxt_state = bif.ap ? ST_WRAP : ST_WR;
        end
      end
      ST_RD, ST_WR: begin
        if (bif.rd_go) begin
          nxt_state = bif.ap ? ST_RDAP : ST_RD;
        end else if (bif.wr_go) begin
          nxt_state = bif.ap ? ST_WRAP : ST_WR;
        end else if (bif.other_go || bif.burst_end) begin
          nxt_state = ST_OPEN;
        end
      end
      ST_RDAP: begin
        if (bif.other_go || bif.burst_end) begin
          nxt_state = ST_PRE;
          nxt_pre   = 1'b1;
          nxt_cnt   = CNT_W'(TRP - 1);
        end
      end
      ST_WRAP: begin
        if (bif.other_go || bif.burst_end) begin
          nxt_state = ST_WREC;
          nxt_cnt   = CNT_W'(TWR - 1);
        end
      end
      ST_WREC: begin
        if (cnt_ff == CNT_RST) begin
          nxt_state = ST_PRE;
          nxt_pre   = 1'b1;
          nxt_cnt   = CNT_W'(TRP - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ST_PRE: begin
        if (cnt_ff == CNT_RST) begin
          nxt_state = ST_OPEN;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = ST_OPEN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= ST_OPEN;
      cnt_ff   <= CNT_RST;
      pre_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      pre_ff   <= nxt_pre;
    end
  end

  assign bif.state     = state_ff;
  assign bif.pre_start = pre_ff;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  sequence s_wrap_cut;
    state_ff == ST_WRAP && bif.other_go;
  endsequence

  property p_rd_cut_opens;
    @(posedge mclk) disable iff (sys_rst)
      (state_ff == ST_RD && bif.other_go) |=> state_ff == ST_OPEN;
  endproperty
  a_rd_cut_opens: assert property (p_rd_cut_opens)
    else $error("read burst not ended by other-bank command");

  property p_rdap_end_pre;
    @(posedge mclk) disable iff (sys_rst)
      (state_ff == ST_RDAP && bif.burst_end && !bif.other_go) |=> pre_ff;
  endproperty
  a_rdap_end_pre: assert property (p_rdap_end_pre)
    else $error("auto precharge missing after burst end");

  property p_rdap_cut_pre;
    @(posedge mclk) disable iff (sys_rst)
      (state_ff == ST_RDAP && bif.other_go) |=> (pre_ff && state_ff == ST_PRE);
  endproperty
  a_rdap_cut_pre: assert property (p_rdap_cut_pre)
    else $error("precharge not started at interrupting command");

  property p_wrap_cut_pre;
    @(posedge mclk) disable iff (sys_rst)
      s_wrap_cut |=> !pre_ff ##TWR pre_ff;
  endproperty
  a_wrap_cut_pre: assert property (p_wrap_cut_pre)
    else $error("precharge not delayed by write recovery");

  property p_open_holds;
    @(posedge mclk) disable iff (sys_rst)
      (state_ff == ST_OPEN && bif.other_go) |=> state_ff == ST_OPEN;
  endproperty
  a_open_holds: assert property (p_open_holds)
    else $error("bank disturbed by command to another bank");

endmodule // sbi_bank

// file: logic/sbi_rd_pipe.sv
`timescale 1ns/1ps
module sbi_rd_pipe
  import sbi_pkg::*;
#(
  parameter int CL = CAS_LAT,
  parameter int W  = DATA_W
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         beat_vld,
  input  wire logic [W-1:0] beat_data,
  input  wire logic         flush,
  input  wire logic         dqm,
  output logic      [W-1:0] dq_out,
  output logic              dq_oe
);

  logic [CL-1:0]      vld_ff;
  logic [CL-1:0]      nxt_vld;
  logic [W-1:0]       data_ff [CL];
  logic [W-1:0]       nxt_data [CL];
  logic [DQZ_CYC-1:0] dqm_ff;
  logic [DQZ_CYC-1:0] nxt_dqm;
  logic [W-1:0]       out_ff;
  logic [W-1:0]       nxt_out;
  logic               oe_ff;
  logic               nxt_oe;

  // ----------------------------------------------------------------
  // Latency line and output gating.
  // ----------------------------------------------------------------
  always_comb begin
    nxt_vld     = {vld_ff[CL-2:0], beat_vld} & {CL{~flush}};
    nxt_data[0] = beat_data;
    for (int i = 1; i < CL; i++) begin
      nxt_data[i] = data_ff[i-1];
    end
    nxt_dqm = {dqm_ff[DQZ_CYC-2:0], dqm};
    nxt_out = data_ff[CL-1];
    nxt_oe  = vld_ff[CL-1] & ~dqm_ff[DQZ_CYC-1] & ~flush;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vld_ff <= '0;
      dqm_ff <= '0;
      out_ff <= '0;
      oe_ff  <= 1'b0;
      for (int i = 0; i < CL; i++) begin
        data_ff[i] <= '0;
      end
    end else begin
      vld_ff  <= nxt_vld;
      dqm_ff  <= nxt_dqm;
      out_ff  <= nxt_out;
      oe_ff   <= nxt_oe;
      data_ff <= nxt_data;
    end
  end

  assign dq_out = out_ff;
  assign dq_oe  = oe_ff;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  property p_flush_off;
    @(posedge mclk) disable iff (sys_rst)
      flush |=> !dq_oe;
  endproperty
  a_flush_off: assert property (p_flush_off)
    else $error("read output not cut by write");

  property p_dqm_hiz;
    @(posedge mclk) disable iff (sys_rst)
      dqm |-> ##3 !dq_oe;
  endproperty
  a_dqm_hiz: assert property (p_dqm_hiz)
    else $error("mask did not turn outputs off two clocks later");

  sequence s_clean_beat;
    (beat_vld && !flush && !dqm) ##1 (!flush && !dqm) ##1 !flush;
  endsequence

  property p_cas_lat;
    @(posedge mclk) disable iff (sys_rst)
      s_clean_beat |=> (dq_oe && dq_out == $past(beat_data, 3));
  endproperty
  a_cas_lat: assert property (p_cas_lat)
    else $error("read data not driven at CAS latency");

endmodule // sbi_rd_pipe

// file: bench/sbi_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Controller model driving command, mask and write data.
// ----------------------------------------------------------------------
module sbi_ctrl_model
  import sbi_pkg::*;
(
  input  wire logic              mclk,
  output logic                   cs_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic [1:0]             ba,
  output logic                   ap_en,
  output logic [COL_W-1:0]       col,
  output logic                   dqm,
  output logic [DATA_W-1:0]      dq_in
);
  int wr_left = 0;

  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    {ba, ap_en, col, dqm, dq_in} = '0;
  end

  // Only READ and WRITE are ever encoded, so no burst stop reaches another bank.
  task automatic put(input logic c, input logic w, input logic [1:0] b, input logic a,
                     input logic [COL_W-1:0] cl, input logic m);
    @(negedge mclk);
    cs_n  = ~c;
    cas_n = ~c;
    we_n  = ~(c & w);
    ba    = b;
    ap_en = a;
    col   = cl;
    dqm   = m;
    if (c) wr_left = w ? BURST_LEN : 0;
    // An idle data bus shows the inverse of its last value.
    dq_in = (wr_left > 0) ? DATA_W'($urandom) : ~dq_in;
    if (wr_left > 0) wr_left--;
  endtask

  // The mask leads a write that cuts a read, so the two drivers never overlap.
  task automatic wr_cut(input logic [1:0] b, input logic a, input logic [COL_W-1:0] cl,
                        input int lead);
    repeat (lead) put(1'b0, 1'b0, b, a, cl, 1'b1);
    put(1'b1, 1'b1, b, a, cl, 1'b0);
  endtask
endmodule // sbi_ctrl_model

// file: bench/sdram_interbank_burst_interrupt_tb_top.sv
`timescale 1ns/1ps
module sdram_interbank_burst_interrupt_tb_top
  import sbi_pkg::*;
;
  localparam int NC = 1024;
  logic                 mclk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 cs_n, ras_n, cas_n, we_n, ap_en, dqm, dq_oe, wr_acc_vld;
  logic [1:0]           ba, wr_acc_bank, bnk;
  logic [COL_W-1:0]     col, bcol;
  logic [DATA_W-1:0]    dq_in, dq_out, wr_acc_data;
  logic [NUM_BANKS-1:0] pre_start;
  logic                 bap;
  int                   error_cnt = 0;
  int                   num_checks = 0;
  int                   k = -1;
  int                   kind = 0;
  int                   bst = 0;
  logic                 eoe [NC];
  logic                 msk [NC];
  logic                 ewv [NC];
  logic [DATA_W-1:0]    eout [NC];
  logic [DATA_W-1:0]    ewd [NC];
  logic [1:0]           ewb [NC];
  logic [NUM_BANKS-1:0] epre [NC];

  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  sbi_core dut (.mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .ap_en(ap_en), .col(col), .dqm(dqm),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .wr_acc_vld(wr_acc_vld),
    .wr_acc_bank(wr_acc_bank), .wr_acc_data(wr_acc_data), .pre_start(pre_start));

  sbi_ctrl_model ctl (.mclk(mclk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .ap_en(ap_en), .col(col), .dqm(dqm), .dq_in(dq_in));

  // ----------------------------------------------------------------------
  // Reference model, updated from the inputs seen at each rising edge.
  // ----------------------------------------------------------------------
  task automatic beat(input int i);
    if (kind == 1) begin
      eoe[k+2]  = 1'b1;
      eout[k+2] = {bnk, 5'h00, bcol + COL_W'(i)};
    end else if (!dqm) begin
      ewv[k] = 1'b1;
      ewb[k] = bnk;
      ewd[k] = dq_in;
    end
    if (bap && i == BURST_LEN - 1) epre[k + ((kind == 2) ? TWR_CYC : 0)][bnk] = 1'b1;
  endtask

  always @(posedge mclk) begin
    k = k + 1;
    if (sys_rst) begin
      kind = 0;
      for (int i = 0; i < 4; i++) begin
        eoe[k+i]  = 1'b0;
        epre[k+i] = '0;
      end
    end else begin
      if (dqm) msk[k+2] = 1'b1;
      if (kind != 0 && k - bst < BURST_LEN) begin
        if (!cs_n && !cas_n) begin
          if (bap) epre[k + ((kind == 2) ? TWR_CYC : 0)][bnk] = 1'b1;
        end else begin
          beat(k - bst);
        end
      end
      if (!cs_n && !cas_n) begin
        // A write drops any read data still in the output line.
        if (!we_n) begin
          eoe[k]   = 1'b0;
          eoe[k+1] = 1'b0;
        end
        kind = we_n ? 1 : 2;
        bnk  = ba;
        bcol = col;
        bst  = k;
        bap  = ap_en;
        beat(0);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Comparison and closing report.
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(negedge mclk) begin
    if (k >= NC - 8) begin
      chk(16'h0001, 16'h0000, "cycle limit");
      summarize();
    end
    if (k >= 0) begin
      chk(16'(dq_oe), 16'(eoe[k] & !msk[k]), "dq_oe");
      if (eoe[k] && !msk[k]) chk(dq_out, eout[k], "dq_out");
      chk(16'(wr_acc_vld), 16'(ewv[k]), "wr_acc_vld");
      if (ewv[k]) chk(16'(wr_acc_bank), 16'(ewb[k]), "wr_acc_bank");
      if (ewv[k]) chk(wr_acc_data, ewd[k], "wr_acc_data");
      chk(16'(pre_start), 16'(epre[k]), "pre_start");
    end
  end

  // ----------------------------------------------------------------------
  // Stimulus.
  // ----------------------------------------------------------------------
  task automatic op(input logic c, input logic w, input int b, input logic a, input logic m);
    ctl.put(c, w, 2'(b), a, COL_W'($urandom), m);
  endtask

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 0, 1'b0, 1'b0);
  endtask

  task automatic done(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  initial begin
    int seed;
    for (int i = 0; i < NC; i++) begin
      {eoe[i], msk[i], ewv[i], eout[i], ewd[i], ewb[i], epre[i]} = '0;
    end
    seed = $urandom(75238);
    repeat (20) @(negedge mclk);
    sys_rst = 1'b0;
    idle(2);
    done("reset");
    for (int i = 0; i < 16; i++) begin
      op(1'b1, i[0], i % 4, i[1], 1'b0);
      if (!i[0] && i[2]) begin
        ctl.wr_cut(2'((i + 1) % 4), i[3], COL_W'($urandom), i[1] ? 2 : 1);
      end else begin
        idle(int'(i[3]) + int'(i[1]));
        op(1'b1, i[2], (i + 1) % 4, i[3], 1'b0);
      end
      idle(8);
    end
    done("cross bank interrupt");
    op(1'b1, 1'b1, 2, 1'b0, 1'b0);
    op(1'b0, 1'b0, 0, 1'b0, 1'b1);
    idle(2);
    op(1'b1, 1'b0, 3, 1'b1, 1'b0);
    op(1'b0, 1'b0, 0, 1'b0, 1'b1);
    idle(8);
    done("data mask");
    for (int b = 0; b < NUM_BANKS; b++) op(1'b1, b[0], b, 1'b1, 1'b0);
    idle(8);
    done("bank chain");
    op(1'b1, 1'b0, 1, 1'b1, 1'b0);
    idle(2);
    sys_rst = 1'b1;
    idle(2);
    sys_rst = 1'b0;
    idle(1);
    op(1'b1, 1'b0, 1, 1'b0, 1'b0);
    idle(8);
    done("reset in burst");
    summarize();
  end
endmodule // sdram_interbank_burst_interrupt_tb_top
